// ===== sim/acoc_ctrl_monitor.sv
// Checker on the ports of acoc_ctrl.
// Assumes pins change slowly against i_clk.
`timescale 1ns/10ps
module acoc_ctrl_monitor
	import acoc_pkg::*;
#(
	parameter int VOLT_CYC = CONV_VOLT_CYC,
	parameter int TEMP_CYC = CONV_TEMP_CYC,
	parameter int WK_CYC   = WAKE_CYC
) (
	input wire logic                i_clk,
	input wire logic                i_rst_n,
	input wire logic                i_convert_start_n,
	input wire logic                i_cs_n,
	input wire logic [CHAN_W-1:0]   i_channel,
	input wire logic [THRESH_W-1:0] i_overtemp_threshold_reg,
	input wire logic [RESULT_W-1:0] i_adc_result,
	input wire logic                o_busy,
	input wire logic                o_hold,
	input wire logic                o_power_down,
	input wire logic                o_overtemp_flag_n,
	input wire logic                o_result_strobe
);
	localparam int WK_MAX = WK_CYC + 8;
	logic [CNT_W-1:0] cnt_q;
	always_ff @(posedge i_clk) cnt_q <= o_busy ? cnt_q + 16'h1 : 16'h0;
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_hot;
		o_result_strobe && i_channel == TEMP_CHAN && i_adc_result[9:2] > i_overtemp_threshold_reg;
	endsequence
	property p_start; $fell(i_convert_start_n) && !o_busy && !o_power_down |-> ##[1:5] o_busy;
	endproperty
	a_start: assert property (p_start) else $error("no busy");
	property p_hold; o_hold == o_busy; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_len; $fell(o_busy) |-> o_result_strobe && cnt_q == (i_channel == TEMP_CHAN ?
		TEMP_CYC : VOLT_CYC); endproperty
	a_len: assert property (p_len) else $error("length");
	property p_pd; $fell(o_busy) && !i_convert_start_n |-> ##[0:4] o_power_down; endproperty
	a_pd: assert property (p_pd) else $error("no power-down");
	property p_wake; o_power_down && $rose(i_convert_start_n) |-> ##[WK_CYC:WK_MAX] !o_power_down;
	endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_trip; s_hot |-> ##[0:2] !o_overtemp_flag_n; endproperty
	a_trip: assert property (p_trip) else $error("no trip");
	property p_fall; $fell(o_overtemp_flag_n) |-> o_result_strobe || $past(o_result_strobe) ||
		$past(o_result_strobe, 2); endproperty
	a_fall: assert property (p_fall) else $error("stray trip");
	property p_rise; $rose(o_overtemp_flag_n) |-> !i_cs_n; endproperty
	a_rise: assert property (p_rise) else $error("stray clear");
endmodule
bind acoc_ctrl acoc_ctrl_monitor #(.VOLT_CYC(VOLT_CYC), .TEMP_CYC(TEMP_CYC), .WK_CYC(WK_CYC))
	mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_convert_start_n(i_convert_start_n),
	.i_cs_n(i_cs_n), .i_channel(i_channel), .i_overtemp_threshold_reg(i_overtemp_threshold_reg),
	.i_adc_result(i_adc_result), .o_busy(o_busy), .o_hold(o_hold), .o_power_down(o_power_down),
	.o_overtemp_flag_n(o_overtemp_flag_n), .o_result_strobe(o_result_strobe));

// ===== sim/acoc_host_model.sv
// Host model: convert pulses and serial reads.
// Assumes busy from the block; serial clock idles low.
`timescale 1ns/10ps
module acoc_host_model (
	input  wire logic i_clk,
	input  wire logic i_busy,
	output logic      o_convert_start_n,
	output logic      o_cs_n,
	output logic      o_rd_wr,
	output logic      o_sclk
);
	initial begin
		o_convert_start_n = 1'b1;
		o_cs_n = 1'b1;
		o_rd_wr = 1'b0;
		o_sclk = 1'b0;
	end
	task automatic convert(input int low);
		o_convert_start_n <= 1'b0;
		repeat (low) @(posedge i_clk);
		o_convert_start_n <= 1'b1;
		wait (i_busy === 1'b0);
	endtask
	// Odd offset keeps serial edges off the system clock edges
	task automatic read(input logic cs, input int n);
		#13 o_cs_n = cs;
		repeat (n) begin
			#40 o_sclk = 1'b1;
			#40 o_sclk = 1'b0;
			o_rd_wr = 1'b1;
		end
		o_rd_wr = 1'b0;
		#40 o_cs_n = 1'b1;
	endtask
endmodule

// ===== sim/test_adc_conversion_overtemp_control.sv
// Bench for acoc_ctrl with short counts.
// Assumes the host model drives the pins.
`timescale 1ns/10ps
module test_adc_conversion_overtemp_control
	import acoc_pkg::*;
;
	logic i_clk, i_rst_n, i_sclk, i_sclk_rst_n, i_convert_start_n, i_cs_n, i_rd_wr;
	logic o_busy, o_hold, o_power_down, o_overtemp_flag_n, o_result_strobe;
	logic [CHAN_W-1:0]   i_channel;
	logic [THRESH_W-1:0] i_overtemp_threshold_reg;
	logic [RESULT_W-1:0] i_adc_result;
	int                  fails, comparisons;
	acoc_ctrl #(.VOLT_CYC(20), .TEMP_CYC(60), .WK_CYC(8)) uut (.*);
	acoc_host_model host (.i_clk(i_clk), .i_busy(o_busy), .o_convert_start_n(i_convert_start_n),
		.o_cs_n(i_cs_n), .o_rd_wr(i_rd_wr), .o_sclk(i_sclk));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic run(input logic [2:0] c, input logic [9:0] r, input logic [7:0] t, input int low);
		@(posedge i_clk);
		i_channel <= c;
		i_adc_result <= r;
		i_overtemp_threshold_reg <= t;
		host.convert(low);
		@(negedge i_clk);
	endtask
	task automatic t_volt();
		run(3'h1, 10'h3FF, 8'h00, 10);
		check(o_busy, 1'b0);
		check(o_result_strobe, 1'b1);
		check(o_hold, 1'b0);
		check(o_power_down, 1'b0);
		check(o_overtemp_flag_n, 1'b1);
	endtask
	// Equal top bits must not trip; one above must
	task automatic t_temp();
		run(3'h0, 10'h203, 8'h80, 10);
		check(o_overtemp_flag_n, 1'b1);
		run(3'h0, 10'h204, 8'h80, 80);
		check(o_power_down, 1'b1);
		check(o_overtemp_flag_n, 1'b0);
		repeat (20) @(negedge i_clk);
		check(o_power_down, 1'b0);
	endtask
	task automatic t_sticky();
		run(3'h0, 10'h000, 8'h80, 10);
		host.read(1'b1, 3);
		check(o_overtemp_flag_n, 1'b0);
		host.read(1'b0, 3);
		check(o_overtemp_flag_n, 1'b1);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial begin
		i_rst_n = 1'b0;
		i_sclk_rst_n = 1'b0;
		i_channel = 3'h1;
		i_overtemp_threshold_reg = 8'hFF;
		i_adc_result = 10'h000;
		fails = 0;
		comparisons = 0;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		host.read(1'b1, 2);
		@(posedge i_clk);
		i_sclk_rst_n <= 1'b1;
		t_volt();
		t_temp();
		t_sticky();
		finish_test();
	end
	initial begin
		#20us;
		fails++;
		finish_test();
	end
endmodule

// ===== verilog/acoc_ctrl.sv
// Conversion sequencer, busy, power-down and overtemperature flag.
// Assumes convert_start_n, cs_n and rd_wr are asynchronous pins; the converter core
// delivers a result with o_result_valid-free timing set by the conversion counter.
`timescale 1ns/10ps
module acoc_ctrl
	import acoc_pkg::*;
#(
	parameter int VOLT_CYC = CONV_VOLT_CYC,
	parameter int TEMP_CYC = CONV_TEMP_CYC,
	parameter int WK_CYC   = WAKE_CYC
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	input  wire logic                i_sclk,
	input  wire logic                i_sclk_rst_n,
	input  wire logic                i_convert_start_n,
	input  wire logic                i_cs_n,
	input  wire logic                i_rd_wr,
	input  wire logic [CHAN_W-1:0]   i_channel,
	input  wire logic [THRESH_W-1:0] i_overtemp_threshold_reg,
	input  wire logic [RESULT_W-1:0] i_adc_result,
	output logic                     o_busy,
	output logic                     o_hold,
	output logic                     o_power_down,
	output logic                     o_overtemp_flag_n,
	output logic                     o_result_strobe
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]          cs_sync;
		logic [1:0]          tgl_sync;
		logic                tgl_prev;
		acoc_state_e         state;
		logic [CNT_W-1:0]    cnt;
		logic                temp_conv;
		logic                busy;
		logic                hold;
		logic                pdown;
		logic                flag_n;
		logic                strobe;
	} acoc_ctrl_s;

	acoc_ctrl_s r_q;
	acoc_ctrl_s r_d;
	logic       read_tgl;

	// Synchroniser stages kept apart from the struct so only stage two is read
	logic [1:0] cv_sync_q;
	logic       cv_prev_q;

	acoc_read_detect u_read_detect (
		.i_sclk     (i_sclk),
		.i_rst_n    (i_sclk_rst_n),
		.i_cs_n     (i_cs_n),
		.i_rd_wr    (i_rd_wr),
		.o_read_tgl (read_tgl)
	);

	function automatic logic [CNT_W-1:0] conv_len(input logic is_temp);
		conv_len = is_temp ? CNT_W'(TEMP_CYC - 1) : CNT_W'(VOLT_CYC - 1);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic cv_fall;
	logic cv_rise;
	logic read_done;
	logic over;

	always_comb begin
		cv_fall   = cv_prev_q && !cv_sync_q[1];
		cv_rise   = !cv_prev_q && cv_sync_q[1];
		read_done = r_q.tgl_sync[1] != r_q.tgl_prev;
		over      = i_adc_result[RESULT_W-1 -: THRESH_W] > i_overtemp_threshold_reg;
		r_d = r_q;
		r_d.cs_sync  = {r_q.cs_sync[0], i_cs_n};
		r_d.tgl_sync = {r_q.tgl_sync[0], read_tgl};
		r_d.tgl_prev = r_q.tgl_sync[1];
		r_d.strobe   = 1'b0;
		case (r_q.state)
			ACOC_IDLE: begin
				if (cv_fall) begin
					r_d.state     = ACOC_CONV;
					r_d.hold      = 1'b1;
					r_d.busy      = 1'b1;
					r_d.temp_conv = (i_channel == TEMP_CHAN);
					r_d.cnt       = conv_len(i_channel == TEMP_CHAN);
				end
			end
			ACOC_CONV: begin
				if (r_q.cnt == '0) begin
					r_d.busy   = 1'b0;
					r_d.hold   = 1'b0;
					r_d.strobe = 1'b1;
					// Low level at the end means the host wants power-down
					if (!cv_sync_q[1]) begin
						r_d.state = ACOC_DOWN;
						r_d.pdown = 1'b1;
					end else begin
						r_d.state = ACOC_IDLE;
					end
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			ACOC_DOWN: begin
				if (cv_rise) begin
					r_d.state = ACOC_WAKE;
					r_d.cnt   = CNT_W'(WK_CYC - 1);
				end
			end
			ACOC_WAKE: begin
				// Wake delay counts WK_CYC cycles from the synchronised rise, 2 us at the default, so a later fall is seen
				if (r_q.cnt == '0) begin
					r_d.state = ACOC_IDLE;
					r_d.pdown = 1'b0;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				r_d.state = ACOC_IDLE;
			end
		endcase
		// ----------------------------------------
		// Overtemperature flag; a new trip wins over a clear in the same cycle
		// ----------------------------------------
		if (read_done && !r_q.cs_sync[1]) begin
			r_d.flag_n = 1'b1;
		end
		if (r_q.state == ACOC_CONV && r_q.cnt == '0 && r_q.temp_conv && over) begin
			r_d.flag_n = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cv_sync_q <= 2'h3;
			cv_prev_q <= 1'b1;
			r_q       <= '{cs_sync: 2'h3, tgl_sync: 2'h0, tgl_prev: 1'b0,
				state: ACOC_IDLE, cnt: '0, temp_conv: 1'b0, busy: 1'b0,
				hold: 1'b0, pdown: 1'b0, flag_n: 1'b1, strobe: 1'b0};
		end else begin
			cv_sync_q <= {cv_sync_q[0], i_convert_start_n};
			cv_prev_q <= cv_sync_q[1];
			r_q       <= r_d;
		end
	end

	assign o_busy            = r_q.busy;
	assign o_hold            = r_q.hold;
	assign o_power_down      = r_q.pdown;
	assign o_overtemp_flag_n = r_q.flag_n;
	assign o_result_strobe   = r_q.strobe;
endmodule

// ===== verilog/acoc_pkg.sv
// Constants for the conversion and overtemperature control block.
// Assumes a 200 MHz system clock and a host-driven serial clock domain.
// Summary of operation
// - A falling edge on convert_start_n begins one 10-bit conversion.
// - That same falling edge switches the sampling stage from track to hold.
// - When a conversion completes, the sampling stage returns to tracking.
// - At the end of each conversion a low convert_start_n puts the device in power-down.
// - Busy is high for the whole of any conversion and low otherwise.
// - After a channel 0 conversion, a result above the 8-bit threshold drives the flag low.
// - The flag returns high when a serial read ends: read/write rises while select is low.
// - The serial port responds only while chip select is low.
// - Output data shifts on falling serial clock edges, input data on rising ones.
// - A voltage conversion ends within 9 us and a temperature conversion within 27 us.
// - From power-down the device wakes within 2 us of a rising convert_start_n edge.
package acoc_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int T_CONV_VOLT_NS  = 9000;
	localparam int T_CONV_TEMP_NS  = 27000;
	localparam int T_WAKE_NS       = 2000;
	// Longest times round down
	localparam int CONV_VOLT_CYC   = (T_CONV_VOLT_NS * 1000) / CLK_PERIOD_PS;
	localparam int CONV_TEMP_CYC   = (T_CONV_TEMP_NS * 1000) / CLK_PERIOD_PS;
	localparam int WAKE_CYC        = (T_WAKE_NS * 1000) / CLK_PERIOD_PS;
	// ----------------------------------------
	// Widths and fields
	// ----------------------------------------
	localparam int RESULT_W        = 10;
	localparam int THRESH_W        = 8;
	localparam int CHAN_W          = 3;
	localparam int CNT_W           = 16;
	localparam logic [CHAN_W-1:0] TEMP_CHAN     = 3'h0;
	localparam logic [THRESH_W-1:0] THRESH_RST  = 8'hFF;
	typedef enum logic [1:0] {
		ACOC_IDLE,
		ACOC_CONV,
		ACOC_DOWN,
		ACOC_WAKE
	} acoc_state_e;
endpackage

// ===== verilog/acoc_read_detect.sv
// Serial-clock side detector of a completed read.
// Assumes i_sclk is the host serial clock; emits a toggle per finished read.
`timescale 1ns/10ps
module acoc_read_detect
	import acoc_pkg::*;
(
	input  wire logic i_sclk,
	input  wire logic i_rst_n,
	input  wire logic i_cs_n,
	input  wire logic i_rd_wr,
	output logic      o_read_tgl
);
	typedef struct packed {
		logic rdwr_prev;
		logic tgl;
	} acoc_rd_s;

	acoc_rd_s r_q;
	acoc_rd_s r_d;

	// Level sampled on rising clock edges, as input data is captured there
	always_comb begin
		r_d = r_q;
		r_d.rdwr_prev = i_rd_wr;
		if (!i_cs_n && i_rd_wr && !r_q.rdwr_prev) begin
			r_d.tgl = ~r_q.tgl;
		end
	end

	always_ff @(posedge i_sclk) begin
		if (!i_rst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign o_read_tgl = r_q.tgl;
endmodule
